//--- hdl/cpu_privilege_mode_control.sv
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Two mode bits: super-system picks a sub-mode, system bit, both clear means user.
// - A system-vector call sets the system mode bit.
// - System-vector calls are legal only in user mode, else an exception.
// - Every exception entry sets the system mode bit.
// - A system-writable setting chooses whether interrupts run in system mode.
// - Interrupt return restores both mode bits saved at entry.
// - User-mode return needs user-mode interrupts and an active interrupt, else exception.
// - A far call to the user entry address from system mode enters user mode.
// - The user entry call pushes no return address.
// - Register writes can only clear the mode bits.
// - System mode reaches every special function register.
// - User mode reaches a peripheral group only when system code granted it.
// - Application code reaches the super-system sub-modes only by an interrupt return to a frame saved there.
// - Refused writes do nothing, refused reads return a fixed value.
// - Outside user mode all sixteen groups report full access.

module cpu_privilege_mode_control #(
   parameter int STACK_DEPTH = mode_ctrl_pkg::STACK_DEPTH
) (
   input  wire logic                                clk,
   input  wire logic                                rst,
   input  wire mode_ctrl_pkg::cpu_event_s           cpu_event,
   input  wire mode_ctrl_pkg::bus_req_s             bus_req,
   input  wire logic [1:0]                          sub_mode_strap,
   input  wire logic                                periph_req,
   input  wire logic [mode_ctrl_pkg::GROUP_W-1:0]   periph_group,
   output logic [mode_ctrl_pkg::DATA_W-1:0]         rdata,
   output mode_ctrl_pkg::mode_s                     mode_status,
   output mode_ctrl_pkg::sub_mode_e                 sub_mode,
   output logic                                     interrupt_active,
   output logic                                     raise_exception,
   output logic                                     return_push,
   output logic                                     user_entry,
   output logic [mode_ctrl_pkg::GROUPS-1:0]         periph_rights,
   output logic                                     periph_allow,
   output logic                                     periph_deny,
   output logic                                     irq
);

   if (STACK_DEPTH < 2)
   begin : g_check
      $error("cpu_privilege_mode_control: STACK_DEPTH must be at least 2");
   end

   typedef struct packed
   {
      mode_ctrl_pkg::mode_s              mode;
      mode_ctrl_pkg::sub_mode_e          sub;
      logic                              irq_sys;
      logic [mode_ctrl_pkg::GROUPS-1:0]  grant;
      logic [mode_ctrl_pkg::EV_W-1:0]    ev_stat;
      logic [mode_ctrl_pkg::EV_W-1:0]    ev_en;
      logic [mode_ctrl_pkg::DATA_W-1:0]  rdata;
      logic                              irq_act;
      logic                              raise;
      logic                              push_ret;
      logic                              user_entry;
      logic [mode_ctrl_pkg::GROUPS-1:0]  rights;
      logic                              allow;
      logic                              deny;
      logic                              irq;
      logic [1:0]                        strap_s1;
      logic [1:0]                        strap_s2;
      logic [1:0]                        strap_cnt;
   } state_s;

   state_s q;
   state_s next_q;

   logic                             push;
   logic                             pop;
   mode_ctrl_pkg::frame_s            push_data;
   mode_ctrl_pkg::frame_s            stack_top;
   logic                             stack_empty;
   logic                             stack_full;
   logic [mode_ctrl_pkg::GROUPS-1:0] guard_rights;
   logic                             guard_allow;
   logic                             guard_deny;

   mode_return_stack #(
      .DEPTH (STACK_DEPTH)
   ) u_stack (
      .clk       (clk),
      .rst       (rst),
      .push      (push),
      .pop       (pop),
      .push_data (push_data),
      .top       (stack_top),
      .empty     (stack_empty),
      .full      (stack_full)
   );

   register_access_guard #(
      .GROUPS (mode_ctrl_pkg::GROUPS)
   ) u_guard (
      .mode   (q.mode),
      .grant  (q.grant),
      .req    (periph_req),
      .group  (periph_group),
      .rights (guard_rights),
      .allow  (guard_allow),
      .deny   (guard_deny)
   );

   always_comb
   begin
      logic                           in_user;
      logic                           in_sys;
      logic                           privileged;
      logic                           enter_exc;
      logic                           interrupt_return_instruction_ok;
      logic [mode_ctrl_pkg::EV_W-1:0] ev_set;
      logic [mode_ctrl_pkg::EV_W-1:0] ev_clr;
      logic [mode_ctrl_pkg::DATA_W-1:0] rd_val;

      in_user    = !q.mode.ssm && !q.mode.sm;
      in_sys     = !q.mode.ssm && q.mode.sm;
      privileged = !in_user;
      enter_exc  = 1'b0;
      interrupt_return_instruction_ok    = 1'b0;
      ev_set     = '0;
      ev_clr     = '0;
      rd_val     = mode_ctrl_pkg::FIXED_READ;

      next_q            = q;
      next_q.raise      = 1'b0;
      next_q.push_ret   = 1'b0;
      next_q.user_entry = 1'b0;
      push              = 1'b0;
      pop               = 1'b0;
      push_data         = '{mode: q.mode, from_irq: 1'b0};

      // Strap synchroniser; sub-mode caught once after reset release
      next_q.strap_s1 = sub_mode_strap;
      next_q.strap_s2 = q.strap_s1;
      if (q.strap_cnt != mode_ctrl_pkg::STRAP_SETTLE)
      begin
         next_q.strap_cnt = q.strap_cnt + 2'h1;
         case (q.strap_s2)
            2'b01:   next_q.sub = mode_ctrl_pkg::SUB_TEST;
            2'b10:   next_q.sub = mode_ctrl_pkg::SUB_VENDOR;
            default: next_q.sub = mode_ctrl_pkg::SUB_BOOT;
         endcase
      end

      // CPU mode transitions, one event per cycle by priority
      if (cpu_event.exception)
      begin
         enter_exc = 1'b1;
      end
      else if (cpu_event.interrupt)
      begin
         push_data.from_irq = 1'b1;
         push               = 1'b1;
         if (stack_full)
         begin
            ev_set[mode_ctrl_pkg::EV_OVERFLOW] = 1'b1;
         end
         if (q.irq_sys)
         begin
            next_q.mode.sm = 1'b1;
         end
      end
      else if (cpu_event.system_vector_call)
      begin
         if (in_user)
         begin
            push            = 1'b1;
            next_q.mode.sm  = 1'b1;
            next_q.push_ret = 1'b1;
            if (stack_full)
            begin
               ev_set[mode_ctrl_pkg::EV_OVERFLOW] = 1'b1;
            end
         end
         else
         begin
            next_q.raise = 1'b1;
            ev_set[mode_ctrl_pkg::EV_BAD_SYSTEM_VECTOR_CALL] = 1'b1;
            enter_exc = 1'b1;
         end
      end
      else if (cpu_event.interrupt_return_instruction)
      begin
         interrupt_return_instruction_ok = !stack_empty && (privileged || (!q.irq_sys && stack_top.from_irq));
         if (interrupt_return_instruction_ok)
         begin
            pop         = 1'b1;
            next_q.mode = stack_top.mode;
         end
         else
         begin
            next_q.raise = 1'b1;
            ev_set[mode_ctrl_pkg::EV_BAD_INTERRUPT_RETURN_INSTRUCTION] = 1'b1;
            enter_exc = 1'b1;
         end
      end
      else if (cpu_event.far_call && in_sys &&
               (cpu_event.call_target == mode_ctrl_pkg::USER_ENTRY_ADDR))
      begin
         next_q.mode.sm    = 1'b0;
         next_q.user_entry = 1'b1;
         ev_set[mode_ctrl_pkg::EV_USER_ENTRY] = 1'b1;
      end

      if (enter_exc)
      begin
         push           = 1'b1;
         next_q.mode.sm = 1'b1;
         if (stack_full)
         begin
            ev_set[mode_ctrl_pkg::EV_OVERFLOW] = 1'b1;
         end
      end

      // Register writes
      if (bus_req.wr)
      begin
         case (bus_req.addr)
            mode_ctrl_pkg::REG_MODE_STATUS:
            begin
               // Clear-only; no write path ever sets the super-system bit
               next_q.mode.sm  = next_q.mode.sm && bus_req.wdata[mode_ctrl_pkg::MS_SM_BIT];
               next_q.mode.ssm = next_q.mode.ssm && bus_req.wdata[mode_ctrl_pkg::MS_SSM_BIT];
            end
            mode_ctrl_pkg::REG_MODE_CONFIG:
            begin
               if (privileged)
               begin
                  next_q.irq_sys = bus_req.wdata[mode_ctrl_pkg::MC_IRQ_SYS];
               end
            end
            mode_ctrl_pkg::REG_GROUP_GRANT:
            begin
               if (privileged)
               begin
                  next_q.grant = bus_req.wdata;
               end
            end
            mode_ctrl_pkg::REG_EVENT_CLEAR:
            begin
               if (privileged)
               begin
                  ev_clr = bus_req.wdata[mode_ctrl_pkg::EV_W-1:0];
               end
            end
            mode_ctrl_pkg::REG_EVENT_ENABLE:
            begin
               if (privileged)
               begin
                  next_q.ev_en = bus_req.wdata[mode_ctrl_pkg::EV_W-1:0];
               end
            end
            default:
            begin
               next_q.ev_en = next_q.ev_en;
            end
         endcase
      end

      // Sticky events: a set in the clearing cycle wins
      next_q.ev_stat = (q.ev_stat & ~ev_clr) | ev_set;
      next_q.irq     = |(next_q.ev_stat & next_q.ev_en);

      // Register reads, answered in the next cycle
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            mode_ctrl_pkg::REG_MODE_STATUS:
            begin
               rd_val = '0;
               rd_val[mode_ctrl_pkg::MS_SM_BIT]  = q.mode.sm;
               rd_val[mode_ctrl_pkg::MS_SSM_BIT] = q.mode.ssm;
               rd_val[mode_ctrl_pkg::MS_SUB_LSB +: 2] = q.sub;
               rd_val[mode_ctrl_pkg::MS_IRQ_ACTIVE] = q.irq_act;
            end
            mode_ctrl_pkg::REG_MODE_CONFIG:
            begin
               rd_val = '0;
               rd_val[mode_ctrl_pkg::MC_IRQ_SYS] = q.irq_sys;
            end
            mode_ctrl_pkg::REG_GROUP_GRANT:
            begin
               rd_val = q.grant;
            end
            mode_ctrl_pkg::REG_EVENT_STATUS:
            begin
               if (privileged)
               begin
                  rd_val = {{(mode_ctrl_pkg::DATA_W - mode_ctrl_pkg::EV_W){1'b0}}, q.ev_stat};
               end
            end
            mode_ctrl_pkg::REG_EVENT_ENABLE:
            begin
               if (privileged)
               begin
                  rd_val = {{(mode_ctrl_pkg::DATA_W - mode_ctrl_pkg::EV_W){1'b0}}, q.ev_en};
               end
            end
            default:
            begin
               rd_val = mode_ctrl_pkg::FIXED_READ;
            end
         endcase
      end
      next_q.rdata = rd_val;

      // Interrupt frame on top of the return stack after this cycle's push; cleared for one cycle after a pop
      if (push && !stack_full)
      begin
         next_q.irq_act = push_data.from_irq;
      end
      else if (pop)
      begin
         next_q.irq_act = 1'b0;
      end
      else
      begin
         next_q.irq_act = !stack_empty && stack_top.from_irq;
      end

      // Peripheral access answer, registered
      next_q.rights = guard_rights;
      next_q.allow  = guard_allow;
      next_q.deny   = guard_deny;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q            <= '0;
         q.mode.ssm   <= mode_ctrl_pkg::RST_SSM;
         q.mode.sm    <= mode_ctrl_pkg::RST_SM;
         q.sub        <= mode_ctrl_pkg::SUB_BOOT;
         q.irq_sys    <= mode_ctrl_pkg::RST_IRQ_SYS;
         q.grant      <= mode_ctrl_pkg::RST_GRANT;
         q.ev_en      <= mode_ctrl_pkg::RST_EV_EN;
         q.rdata      <= mode_ctrl_pkg::FIXED_READ;
         q.rights     <= '1;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign rdata            = q.rdata;
   assign mode_status      = q.mode;
   assign sub_mode         = q.sub;
   assign interrupt_active = q.irq_act;
   assign raise_exception  = q.raise;
   assign return_push      = q.push_ret;
   assign user_entry       = q.user_entry;
   assign periph_rights    = q.rights;
   assign periph_allow     = q.allow;
   assign periph_deny      = q.deny;
   assign irq              = q.irq;

endmodule : cpu_privilege_mode_control

//--- hdl/mode_ctrl_pkg.sv
package mode_ctrl_pkg;

   // Bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Register indices (word address on the plain port)
   localparam logic [3:0] REG_MODE_STATUS  = 4'h0;
   localparam logic [3:0] REG_MODE_CONFIG  = 4'h1;
   localparam logic [3:0] REG_GROUP_GRANT  = 4'h2;
   localparam logic [3:0] REG_EVENT_STATUS = 4'h3;
   localparam logic [3:0] REG_EVENT_CLEAR  = 4'h4;
   localparam logic [3:0] REG_EVENT_ENABLE = 4'h5;

   // Mode status fields
   localparam int MS_SM_BIT     = 0;
   localparam int MS_SSM_BIT    = 1;
   localparam int MS_SUB_LSB    = 2;
   localparam int MS_IRQ_ACTIVE = 4;
   // Mode config fields
   localparam int MC_IRQ_SYS    = 0;
   // Event status fields
   localparam int EV_BAD_SYSTEM_VECTOR_CALL   = 0;
   localparam int EV_BAD_INTERRUPT_RETURN_INSTRUCTION   = 1;
   localparam int EV_OVERFLOW   = 2;
   localparam int EV_USER_ENTRY = 3;
   localparam int EV_W          = 4;

   // Reset values
   localparam logic        RST_SSM     = 1'b1;
   localparam logic        RST_SM      = 1'b1;
   localparam logic        RST_IRQ_SYS = 1'b1;
   localparam logic [15:0] RST_GRANT   = 16'h0000;
   localparam logic [3:0]  RST_EV_EN   = 4'h0;

   // Fixed answer of a refused or unmapped read
   localparam logic [15:0] FIXED_READ = 16'h0000;

   // User entry address for long, absolute and extended calls
   localparam logic [23:0] USER_ENTRY_ADDR = 24'h800000;

   // Peripheral register groups
   localparam int GROUPS  = 16;
   localparam int GROUP_W = 4;

   // Return stack and strap settle defaults
   localparam int STACK_DEPTH = 8;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   typedef enum logic [1:0]
   {
      SUB_BOOT   = 2'b00,
      SUB_TEST   = 2'b01,
      SUB_VENDOR = 2'b10
   } sub_mode_e;

   typedef struct packed
   {
      logic ssm;
      logic sm;
   } mode_s;

   typedef struct packed
   {
      mode_s mode;
      logic  from_irq;
   } frame_s;

   typedef struct packed
   {
      logic        exception;
      logic        interrupt;
      logic        system_vector_call;
      logic        interrupt_return_instruction;
      logic        far_call;
      logic [23:0] call_target;
   } cpu_event_s;

   typedef struct packed
   {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_s;

endpackage : mode_ctrl_pkg

//--- hdl/mode_return_stack.sv
`timescale 1ns/1ps

module mode_return_stack #(
   parameter int DEPTH = mode_ctrl_pkg::STACK_DEPTH
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 push,
   input  wire logic                 pop,
   input  wire mode_ctrl_pkg::frame_s push_data,
   output mode_ctrl_pkg::frame_s     top,
   output logic                      empty,
   output logic                      full
);

   localparam int PTR_W = $clog2(DEPTH + 1);

   if (DEPTH < 2)
   begin : g_check
      $error("mode_return_stack: DEPTH must be at least 2");
   end

   typedef struct packed
   {
      mode_ctrl_pkg::frame_s [DEPTH-1:0] mem;
      logic [PTR_W-1:0]                  level;
   } stack_s;

   stack_s q;
   stack_s next_q;

   always_comb
   begin
      next_q = q;
      if (push && (q.level != PTR_W'(DEPTH)))
      begin
         next_q.mem[q.level[PTR_W-1:0]] = push_data;
         next_q.level = q.level + PTR_W'(1);
      end
      else if (pop && (q.level != '0))
      begin
         next_q.level = q.level - PTR_W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign empty = (q.level == '0);
   assign full  = (q.level == PTR_W'(DEPTH));
   assign top   = empty ? '0 : q.mem[q.level - PTR_W'(1)];

endmodule : mode_return_stack

//--- hdl/register_access_guard.sv
`timescale 1ns/1ps

module register_access_guard #(
   parameter int GROUPS = mode_ctrl_pkg::GROUPS
) (
   input  wire mode_ctrl_pkg::mode_s mode,
   input  wire logic [GROUPS-1:0]    grant,
   input  wire logic                 req,
   input  wire logic [$clog2(GROUPS)-1:0] group,
   output logic [GROUPS-1:0]         rights,
   output logic                      allow,
   output logic                      deny
);

   if (GROUPS < 2)
   begin : g_check
      $error("register_access_guard: GROUPS must be at least 2");
   end

   always_comb
   begin
      // Full rights outside user mode, granted groups only in user mode
      rights = (mode.ssm || mode.sm) ? '1 : grant;
      allow  = req && rights[group];
      deny   = req && !rights[group];
   end

endmodule : register_access_guard

//--- tb/cpu_privilege_mode_control_props.sv
`timescale 1ns/1ps

module cpu_privilege_mode_control_props #(
   parameter int STACK_DEPTH = mode_ctrl_pkg::STACK_DEPTH
) (
   input wire logic                              clk,
   input wire logic                              rst,
   input wire mode_ctrl_pkg::cpu_event_s         cpu_event,
   input wire mode_ctrl_pkg::bus_req_s           bus_req,
   input wire logic [1:0]                        sub_mode_strap,
   input wire logic                              periph_req,
   input wire logic [mode_ctrl_pkg::GROUP_W-1:0] periph_group,
   input wire logic [mode_ctrl_pkg::DATA_W-1:0]  rdata,
   input wire mode_ctrl_pkg::mode_s              mode_status,
   input wire mode_ctrl_pkg::sub_mode_e          sub_mode,
   input wire logic                              interrupt_active,
   input wire logic                              raise_exception,
   input wire logic                              return_push,
   input wire logic                              user_entry,
   input wire logic [mode_ctrl_pkg::GROUPS-1:0]  periph_rights,
   input wire logic                              periph_allow,
   input wire logic                              periph_deny,
   input wire logic                              irq
);
   logic [4:0] ev;
   assign ev = {cpu_event.exception, cpu_event.interrupt, cpu_event.system_vector_call, cpu_event.interrupt_return_instruction, cpu_event.far_call};
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_VEC_FROM_USER: assert property (ev == 5'h04 && mode_status == 2'b00 |=> return_push && !raise_exception && mode_status == 2'b01)
      else $error("vector call from user mode not entered");
   AST_VEC_REFUSED: assert property (ev == 5'h04 && mode_status != 2'b00 |=> raise_exception && !return_push && mode_status.sm)
      else $error("vector call outside user mode not refused");
   AST_EXC_SYSTEM: assert property (cpu_event.exception |=> mode_status.sm)
      else $error("exception entry left system bit clear");
   AST_RET_RESTORE: assert property (ev == 5'h04 && mode_status == 2'b00 ##1 ev == 5'h00 ##1 ev == 5'h02
      |=> mode_status == $past(mode_status, 3))
      else $error("return did not restore mode bits");
   AST_RET_USER_REFUSED: assert property (ev == 5'h02 && mode_status == 2'b00 && !interrupt_active |=> raise_exception ##0 mode_status == 2'b01)
      else $error("user return without active interrupt accepted");
   AST_USER_ENTRY: assert property (ev == 5'h01 && cpu_event.call_target == 24'h800000 && mode_status == 2'b01 |=> user_entry && !return_push && mode_status == 2'b00)
      else $error("far call to user entry not taken");
   AST_NO_SUPER_RISE: assert property (!mode_status.ssm |=> !mode_status.ssm)
      else $error("super-system bit set after clear");
   AST_PRIV_ACCESS: assert property (periph_req && mode_status != 2'b00 && $past(mode_status) != 2'b00 |=> periph_allow && !periph_deny)
      else $error("privileged peripheral access refused");
   AST_FULL_RIGHTS: assert property (mode_status != 2'b00 ##1 mode_status != 2'b00 |-> periph_rights == 16'hFFFF)
      else $error("privileged rights not all ones");
   AST_IDLE_READ: assert property (!bus_req.rd |=> rdata == 16'h0000)
      else $error("read data not fixed without read");
endmodule : cpu_privilege_mode_control_props

bind cpu_privilege_mode_control cpu_privilege_mode_control_props #(.STACK_DEPTH(STACK_DEPTH)) props_inst (
   .clk(clk), .rst(rst), .cpu_event(cpu_event), .bus_req(bus_req), .sub_mode_strap(sub_mode_strap),
   .periph_req(periph_req), .periph_group(periph_group), .rdata(rdata), .mode_status(mode_status),
   .sub_mode(sub_mode), .interrupt_active(interrupt_active), .raise_exception(raise_exception),
   .return_push(return_push), .user_entry(user_entry), .periph_rights(periph_rights),
   .periph_allow(periph_allow), .periph_deny(periph_deny), .irq(irq)
);

//--- tb/cpu_core_model.sv
`timescale 1ns/1ps

module cpu_core_model (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 return_push,
   input  wire logic                 user_entry,
   output mode_ctrl_pkg::cpu_event_s cpu_event,
   output int                        n_push
);
   initial cpu_event = '0;
   // Return addresses pushed by the core
   always @(posedge clk)
   begin
      if (rst)
         n_push <= 0;
      else if (return_push && !user_entry)
         n_push <= n_push + 1;
   end
   // One event pulse; target line scrambled once released
   task automatic fire(input logic [4:0] sel, input logic [23:0] tgt);
      @(posedge clk);
      cpu_event <= {sel, tgt};
      @(posedge clk);
      cpu_event <= {5'h00, ~tgt};
   endtask : fire
endmodule : cpu_core_model

//--- tb/cpu_privilege_mode_control_tb.sv
`timescale 1ns/1ps

module cpu_privilege_mode_control_tb;
   localparam logic [4:0] K_EXC = 5'h10;
   localparam logic [4:0] K_IRQ = 5'h08;
   localparam logic [4:0] K_VEC = 5'h04;
   localparam logic [4:0] K_RET = 5'h02;
   localparam logic [4:0] K_FAR = 5'h01;
   logic                      clk = 1'b0;
   logic                      rst = 1'b1;
   mode_ctrl_pkg::cpu_event_s cpu_event;
   mode_ctrl_pkg::bus_req_s   bus_req = '0;
   logic                      periph_req = 1'b0;
   logic [3:0]                periph_group = 4'h0;
   logic [15:0]               rdata;
   mode_ctrl_pkg::mode_s      mode_status;
   mode_ctrl_pkg::sub_mode_e  sub_mode;
   logic                      interrupt_active, raise_exception, return_push, user_entry;
   logic [15:0]               periph_rights;
   logic                      periph_allow, periph_deny, irq;
   int                        n_push, p0;
   int                        miscompares = 0;
   int                        n_tests = 0;
   int                        cycles = 0;

   always #20 clk = ~clk;

   cpu_core_model cpu_core_model_inst (.clk(clk), .rst(rst), .return_push(return_push),
      .user_entry(user_entry), .cpu_event(cpu_event), .n_push(n_push));

   cpu_privilege_mode_control #(.STACK_DEPTH(4)) cpu_privilege_mode_control_inst (
      .clk(clk), .rst(rst), .cpu_event(cpu_event), .bus_req(bus_req), .sub_mode_strap(2'b00),
      .periph_req(periph_req), .periph_group(periph_group), .rdata(rdata), .mode_status(mode_status),
      .sub_mode(sub_mode), .interrupt_active(interrupt_active), .raise_exception(raise_exception),
      .return_push(return_push), .user_entry(user_entry), .periph_rights(periph_rights),
      .periph_allow(periph_allow), .periph_deny(periph_deny), .irq(irq));

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic flag(input string name, input logic exp, input logic got);
      check(name, {15'h0000, exp}, {15'h0000, got});
   endtask : flag

   task automatic mode_is(input logic [1:0] exp);
      check("mode_status", {14'h0000, exp}, {14'h0000, mode_status});
   endtask : mode_is

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1 check("rdata", exp, rdata);
   endtask : rd_chk

   task automatic ev(input logic [4:0] sel, input logic [23:0] tgt);
      cpu_core_model_inst.fire(sel, tgt);
      #1;
   endtask : ev

   task automatic settle;
      @(posedge clk);
      #1;
   endtask : settle

   task automatic preq(input logic [3:0] g, input logic allow);
      @(posedge clk);
      periph_req <= 1'b1;
      periph_group <= g;
      @(posedge clk);
      periph_req <= 1'b0;
      #1 flag("periph_allow", allow, periph_allow);
      flag("periph_deny", !allow, periph_deny);
   endtask : preq

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         miscompares++;
         stop_test();
      end
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk(mode_ctrl_pkg::REG_MODE_STATUS, 16'h0003);
      rd_chk(mode_ctrl_pkg::REG_MODE_CONFIG, 16'h0001);
      rd_chk(mode_ctrl_pkg::REG_GROUP_GRANT, 16'h0000);
      rd_chk(4'hF, 16'h0000);
      check("periph_rights", 16'hFFFF, periph_rights);
      preq(4'h5, 1'b1);
      $display("test reset done");
      wr(mode_ctrl_pkg::REG_MODE_STATUS, 16'hFFFD);
      rd_chk(mode_ctrl_pkg::REG_MODE_STATUS, 16'h0001);
      wr(mode_ctrl_pkg::REG_MODE_STATUS, 16'h0003);
      rd_chk(mode_ctrl_pkg::REG_MODE_STATUS, 16'h0001);
      $display("test clear only done");
      ev(K_VEC, 24'h000000);
      flag("raise_exception", 1'b1, raise_exception);
      mode_is(2'b01);
      flag("irq", 1'b0, irq);
      rd_chk(mode_ctrl_pkg::REG_EVENT_STATUS, 16'h0001);
      wr(mode_ctrl_pkg::REG_EVENT_ENABLE, 16'h0001);
      settle();
      flag("irq", 1'b1, irq);
      wr(mode_ctrl_pkg::REG_EVENT_CLEAR, 16'h0001);
      settle();
      flag("irq", 1'b0, irq);
      rd_chk(mode_ctrl_pkg::REG_EVENT_STATUS, 16'h0000);
      ev(K_RET, 24'h000000);
      mode_is(2'b01);
      $display("test refused vector done");
      wr(mode_ctrl_pkg::REG_GROUP_GRANT, 16'h0008);
      p0 = n_push;
      ev(K_FAR, 24'h7FFFFF);
      flag("user_entry", 1'b0, user_entry);
      mode_is(2'b01);
      ev(K_FAR, 24'h800000);
      flag("user_entry", 1'b1, user_entry);
      mode_is(2'b00);
      settle();
      check("n_push", p0[15:0], n_push[15:0]);
      check("periph_rights", 16'h0008, periph_rights);
      preq(4'h3, 1'b1);
      preq(4'h4, 1'b0);
      wr(mode_ctrl_pkg::REG_GROUP_GRANT, 16'hFFFF);
      rd_chk(mode_ctrl_pkg::REG_GROUP_GRANT, 16'h0008);
      rd_chk(mode_ctrl_pkg::REG_EVENT_STATUS, 16'h0000);
      $display("test user entry done");
      ev(K_VEC, 24'h000000);
      flag("return_push", 1'b1, return_push);
      mode_is(2'b01);
      settle();
      check("n_push", p0[15:0] + 16'h0001, n_push[15:0]);
      ev(K_RET, 24'h000000);
      mode_is(2'b00);
      ev(K_RET, 24'h000000);
      flag("raise_exception", 1'b1, raise_exception);
      mode_is(2'b01);
      ev(K_RET, 24'h000000);
      ev(K_EXC, 24'h000000);
      mode_is(2'b01);
      ev(K_RET, 24'h000000);
      mode_is(2'b00);
      ev(K_VEC, 24'h000000);
      ev(K_RET, 24'h000000);
      mode_is(2'b00);
      $display("test vector and return done");
      ev(K_IRQ, 24'h000000);
      mode_is(2'b01);
      ev(K_RET, 24'h000000);
      ev(K_VEC, 24'h000000);
      wr(mode_ctrl_pkg::REG_MODE_CONFIG, 16'h0000);
      ev(K_RET, 24'h000000);
      ev(K_IRQ, 24'h000000);
      mode_is(2'b00);
      settle();
      flag("interrupt_active", 1'b1, interrupt_active);
      ev(K_RET, 24'h000000);
      flag("raise_exception", 1'b0, raise_exception);
      mode_is(2'b00);
      $display("test user interrupt done");
      stop_test();
   end
endmodule : cpu_privilege_mode_control_tb
